/* File: src/csrb_bank.sv */
// Register bank on the eight-bit control bus, with event collector.
module csrb_bank #(
   parameter logic [4:0] SLAVE_ID = 5'h00,
   parameter int NP = 4,
   parameter int NL = 4
) (
   input wire logic clk_sys,
   input wire logic srst,
   csrb_if.dev bus,
   input wire logic [csrb_pkg::DW-1:0] raw_w,
   output logic [csrb_pkg::DW-1:0] raw_r,
   output logic bus_write_strobe,
   output logic [csrb_pkg::CTL_W-1:0] ctl_r,
   output logic [csrb_pkg::DW-1:0] cnt_r,
   input wire logic [csrb_pkg::DW-1:0] cnt_w,
   input wire logic cnt_we,
   input wire logic [csrb_pkg::DW-1:0] stat_w,
   input wire logic [NP-1:0] pulse_event_input,
   input wire logic [NL-1:0] falling_edge_event_input,
   output logic irq
);
   localparam int NE = NP + NL;

   // -------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------
   logic sel;
   logic wr;
   logic [csrb_pkg::REG_W-1:0] idx;

   // Address layout seen by this bank:
   //    bits 13 to 9 name the slave, so thirty-two banks share one bus;
   //    bits 8 to 0 name the register inside the selected bank.
   // Every bank decodes the slave field itself, so no central decoder
   // is needed and banks can be added without touching shared logic.
   // The read index is decoded on every cycle, not only on writes,
   // because the bus has no read strobe: a read is simply an address
   // that stands for one cycle.
   // The upper five address bits pick one of thirty-two slaves.
   assign sel = bus.adr[csrb_pkg::AW-1:csrb_pkg::REG_W] == SLAVE_ID;
   assign idx = bus.adr[csrb_pkg::REG_W-1:0];
   assign wr = sel & bus.we;

   function automatic logic wr_hit(input logic w, input logic [8:0] a,
                                   input logic [8:0] r);
      wr_hit = w && (a == r);
   endfunction

   // -------------------------------------------------------------
   // Direct register
   // -------------------------------------------------------------
   logic [csrb_pkg::DW-1:0] raw_r_ff;
   logic raw_stb_ff;

   // Stored at the width of the bus word; nothing wider exists here.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         raw_r_ff <= csrb_pkg::RST_BYTE;
      end else if (wr_hit(wr, idx, csrb_pkg::IDX_RAW)) begin
         raw_r_ff <= bus.dat_w;
      end
   end

   // Strobe comes one cycle after the bus write, alongside the data.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         raw_stb_ff <= 1'b0;
      end else begin
         raw_stb_ff <= wr_hit(wr, idx, csrb_pkg::IDX_RAW);
      end
   end

   // -------------------------------------------------------------
   // Managed fields
   // -------------------------------------------------------------
   // ctl: bus read-write, core read-only, sixteen bits in two slices.
   // cnt: bus read-write, core read-write with a load strobe.
   // stat: bus read-only, core write-only, read straight from the core.
   logic [csrb_pkg::CTL_W-1:0] ctl_ff;
   logic [csrb_pkg::DW-1:0] cnt_ff;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctl_ff <= '0;
      end else begin
         if (wr_hit(wr, idx, csrb_pkg::IDX_CTL_HI)) begin
            ctl_ff[15:8] <= bus.dat_w;
         end
         if (wr_hit(wr, idx, csrb_pkg::IDX_CTL_LO)) begin
            ctl_ff[7:0] <= bus.dat_w;
         end
      end
   end

   // When both sides write in one cycle the core's strobe wins, so a
   // core update is never lost to a concurrent bus write.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_ff <= csrb_pkg::RST_BYTE;
      end else if (cnt_we) begin
         cnt_ff <= cnt_w;
      end else if (wr_hit(wr, idx, csrb_pkg::IDX_CNT)) begin
         cnt_ff <= bus.dat_w;
      end
   end

   // -------------------------------------------------------------
   // Event collector
   // -------------------------------------------------------------
   logic [NE-1:0] ev_status;
   logic [NE-1:0] ev_pend;
   logic [NE-1:0] ev_en;
   logic ev_irq;

   csrb_evt #(
      .NP(NP),
      .NL(NL)
   ) u_evt (
      .clk_sys(clk_sys),
      .srst(srst),
      .pulse_in(pulse_event_input),
      .level_in(falling_edge_event_input),
      .en_we(wr_hit(wr, idx, csrb_pkg::IDX_EV_EN)),
      .clr_we(wr_hit(wr, idx, csrb_pkg::IDX_EV_PEND)),
      .wdata(bus.dat_w[NE-1:0]),
      .status(ev_status),
      .pending(ev_pend),
      .enable(ev_en),
      .irq(ev_irq)
   );

   // -------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------
   logic [csrb_pkg::DW-1:0] nxt_rd;
   logic [csrb_pkg::DW-1:0] dat_r_ff;

   // Register map of this bank, one byte per index:
   //    0 direct register, written by the bus, read from the core;
   //    1 and 2 control field, upper slice first;
   //    3 counter field, shared by bus and core;
   //    4 core status byte, read-only on the bus;
   //    5 to 7 event status, pending and enable bits.
   // Event bytes are padded with zeros above the last event bit.
   // Unmapped indices read as zero so that software probing the map
   // sees a defined value rather than a copy of some other register.
   // Reads have no side effects; only a write clears pending bits,
   // which keeps a debugger's read from losing an event.
   // Status has no write decode, so bus writes to it are ignored.
   always_comb begin
      nxt_rd = csrb_pkg::RST_BYTE;
      unique case (idx)
         csrb_pkg::IDX_RAW: nxt_rd = raw_w;
         csrb_pkg::IDX_CTL_HI: nxt_rd = ctl_ff[15:8];
         csrb_pkg::IDX_CTL_LO: nxt_rd = ctl_ff[7:0];
         csrb_pkg::IDX_CNT: nxt_rd = cnt_ff;
         csrb_pkg::IDX_STAT: nxt_rd = stat_w;
         csrb_pkg::IDX_EV_STATUS: nxt_rd[NE-1:0] = ev_status;
         csrb_pkg::IDX_EV_PEND: nxt_rd[NE-1:0] = ev_pend;
         csrb_pkg::IDX_EV_EN: nxt_rd[NE-1:0] = ev_en;
         default: nxt_rd = csrb_pkg::RST_BYTE;
      endcase
   end

   // Unselected slaves return zero so read data can be OR-ed together.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dat_r_ff <= csrb_pkg::RST_BYTE;
      end else begin
         dat_r_ff <= sel ? nxt_rd : csrb_pkg::RST_BYTE;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   // Every output below is a plain flip-flop, so the core sees no
   // glitches from the address decode and can use them across paths
   // without extra timing margin.
   // The direct value and its strobe change together; a core that
   // samples the value only while the strobe is high is always safe.
   assign bus.dat_r = dat_r_ff;
   assign raw_r = raw_r_ff;
   assign bus_write_strobe = raw_stb_ff;
   assign ctl_r = ctl_ff;
   assign cnt_r = cnt_ff;
   assign irq = ev_irq;
endmodule // csrb_bank

/* File: src/csrb_evt.sv */
// Event collector: pending, enable and status bits with interrupt.
module csrb_evt #(
   parameter int NP = 4,
   parameter int NL = 4
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [NP-1:0] pulse_in,
   input wire logic [NL-1:0] level_in,
   input wire logic en_we,
   input wire logic clr_we,
   input wire logic [NP+NL-1:0] wdata,
   output logic [NP+NL-1:0] status,
   output logic [NP+NL-1:0] pending,
   output logic [NP+NL-1:0] enable,
   output logic irq
);
   logic [NL-1:0] lvl_q_ff;
   logic [NP+NL-1:0] pend_ff;
   logic [NP+NL-1:0] en_ff;
   logic irq_ff;
   logic [NP+NL-1:0] set_ev;
   logic [NP+NL-1:0] nxt_pend;
   logic [NP+NL-1:0] nxt_en;

   // Pulse sources sit in the low bits, falling-edge sources above.
   assign set_ev = {lvl_q_ff & ~level_in, pulse_in};
   // A set in the same cycle as a software clear wins.
   assign nxt_pend = (pend_ff & ~(clr_we ? wdata : '0)) | set_ev;
   assign nxt_en = en_we ? wdata : en_ff;

   // Tracker starts low so a source low at reset makes no event.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         lvl_q_ff <= '0;
      end else begin
         lvl_q_ff <= level_in;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pend_ff <= '0;
         en_ff <= '0;
      end else begin
         pend_ff <= nxt_pend;
         en_ff <= nxt_en;
      end
   end

   // Built from next-state values so it tracks the bits with no lag.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_pend & nxt_en);
      end
   end

   assign status = {level_in, {NP{1'b0}}};
   assign pending = pend_ff;
   assign enable = en_ff;
   assign irq = irq_ff;
endmodule // csrb_evt

/* File: src/csrb_if.sv */
// Eight-bit control bus between the master and the register bank.
interface csrb_if;
   logic [13:0] adr;
   logic we;
   logic [7:0] dat_w;
   logic [7:0] dat_r;
   modport dev (input adr, input we, input dat_w, output dat_r);
   modport host (output adr, output we, output dat_w, input dat_r);
endinterface

/* File: src/csrb_master.sv */
// Control bus master steered by software over AXI4-Lite.
module csrb_master (
   input wire logic clk_sys,
   input wire logic srst,
   csrb_if.host bus,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_LATCH} csrb_mst_e;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            o[8*i +: 8] = n[8*i +: 8];
         end
      end
      merge = o;
   endfunction

   // -------------------------------------------------------------
   // AXI4-Lite handshakes
   // -------------------------------------------------------------
   logic awready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [31:0] rdata_ff;
   logic wr_go;

   // Address and data are taken together, only with no response open.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         awready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
      end else begin
         awready_ff <= s_axi_awvalid & s_axi_wvalid & ~bvalid_ff & ~awready_ff;
         if (awready_ff) begin
            bvalid_ff <= 1'b1;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end
   assign wr_go = awready_ff;

   // -------------------------------------------------------------
   // Software registers
   // -------------------------------------------------------------
   logic [31:0] addr_ff, wdat_ff, mask_ff;
   logic [7:0] rdat_ff;
   logic done_ff, irq_ff, start;
   logic nxt_done;
   csrb_mst_e st_ff;

   assign start = wr_go && s_axi_awaddr == csrb_pkg::OFS_CMD && s_axi_wstrb[0]
                  && s_axi_wdata[csrb_pkg::CMD_START] && st_ff == ST_IDLE;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         addr_ff <= csrb_pkg::RST_WORD;
         wdat_ff <= csrb_pkg::RST_WORD;
         mask_ff <= csrb_pkg::RST_WORD;
      end else if (wr_go) begin
         if (s_axi_awaddr == csrb_pkg::OFS_ADDR) begin
            addr_ff <= merge(addr_ff, s_axi_wdata, s_axi_wstrb) & 32'h0000_3fff;
         end
         if (s_axi_awaddr == csrb_pkg::OFS_WDATA) begin
            wdat_ff <= merge(wdat_ff, s_axi_wdata, s_axi_wstrb) & 32'h0000_00ff;
         end
         if (s_axi_awaddr == csrb_pkg::OFS_IRQ_MASK) begin
            mask_ff <= merge(mask_ff, s_axi_wdata, s_axi_wstrb) & 32'h0000_0001;
         end
      end
   end

   // Completion is sticky; a set in the clearing cycle wins.
   assign nxt_done = (done_ff & ~(wr_go && s_axi_awaddr == csrb_pkg::OFS_IRQ_STAT
                      && s_axi_wstrb[0] && s_axi_wdata[0])) | (st_ff == ST_LATCH);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         done_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         done_ff <= nxt_done;
         irq_ff <= nxt_done & mask_ff[0];
      end
   end

   // -------------------------------------------------------------
   // Control bus cycle
   // -------------------------------------------------------------
   logic [13:0] adr_ff;
   logic we_ff;
   logic [7:0] dat_w_ff;

   // The bank registers its read data, so it is sampled one cycle
   // after the address; each transfer moves one eight-bit word.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_ff <= ST_IDLE;
         adr_ff <= 14'h0000;
         we_ff <= 1'b0;
         dat_w_ff <= 8'h00;
         rdat_ff <= 8'h00;
      end else begin
         unique case (st_ff)
            ST_IDLE: begin
               if (start) begin
                  adr_ff <= addr_ff[13:0];
                  we_ff <= s_axi_wdata[csrb_pkg::CMD_WRITE];
                  dat_w_ff <= wdat_ff[7:0];
                  st_ff <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               we_ff <= 1'b0;
               st_ff <= ST_LATCH;
            end
            ST_LATCH: begin
               rdat_ff <= bus.dat_r;
               st_ff <= ST_IDLE;
            end
            // The fourth code of the state register is unused; fall back to idle.
            default: begin
               st_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Read channel
   // -------------------------------------------------------------
   logic [31:0] nxt_rdata;

   always_comb begin
      unique case (s_axi_araddr)
         csrb_pkg::OFS_ADDR: nxt_rdata = addr_ff;
         csrb_pkg::OFS_WDATA: nxt_rdata = wdat_ff;
         csrb_pkg::OFS_CMD: nxt_rdata = {31'h0000_0000, st_ff != ST_IDLE};
         csrb_pkg::OFS_RDATA: nxt_rdata = {24'h00_0000, rdat_ff};
         csrb_pkg::OFS_IRQ_STAT: nxt_rdata = {31'h0000_0000, done_ff};
         csrb_pkg::OFS_IRQ_MASK: nxt_rdata = mask_ff;
         default: nxt_rdata = csrb_pkg::RST_WORD;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= csrb_pkg::RST_WORD;
      end else begin
         arready_ff <= s_axi_arvalid & ~rvalid_ff & ~arready_ff;
         if (arready_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = awready_ff;
   assign s_axi_bresp = csrb_pkg::RESP_OKAY;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = csrb_pkg::RESP_OKAY;
   assign s_axi_rvalid = rvalid_ff;
   assign irq = irq_ff;
   assign bus.adr = adr_ff;
   assign bus.we = we_ff;
   assign bus.dat_w = dat_w_ff;
endmodule // csrb_master

/* File: src/csrb_pkg.sv */
// Shared constants for the control bus bank and its master.
package csrb_pkg;
   // -------------------------------------------------------------
   // Control bus shape
   // -------------------------------------------------------------
   localparam int DW = 8;
   localparam int AW = 14;
   localparam int SLV_W = 5;
   localparam int REG_W = 9;
   localparam int CTL_W = 16;
   localparam logic [DW-1:0] RST_BYTE = 8'h00;
   // -------------------------------------------------------------
   // Bank register indices
   // -------------------------------------------------------------
   localparam logic [REG_W-1:0] IDX_RAW = 9'h000;
   localparam logic [REG_W-1:0] IDX_CTL_HI = 9'h001;
   localparam logic [REG_W-1:0] IDX_CTL_LO = 9'h002;
   localparam logic [REG_W-1:0] IDX_CNT = 9'h003;
   localparam logic [REG_W-1:0] IDX_STAT = 9'h004;
   localparam logic [REG_W-1:0] IDX_EV_STATUS = 9'h005;
   localparam logic [REG_W-1:0] IDX_EV_PEND = 9'h006;
   localparam logic [REG_W-1:0] IDX_EV_EN = 9'h007;
   // -------------------------------------------------------------
   // Master's own AXI4-Lite registers (byte offsets)
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_ADDR = 8'h00;
   localparam logic [7:0] OFS_WDATA = 8'h04;
   localparam logic [7:0] OFS_CMD = 8'h08;
   localparam logic [7:0] OFS_RDATA = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam int CMD_START = 0;
   localparam int CMD_WRITE = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

/* File: test/csr_bank_with_event_manager_tb_top.sv */
// Testbench joining the master and the bank through the control bus.
module csr_bank_with_event_manager_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] SID = 5'h03;
   logic clk_sys, srst, cnt_we, bus_write_strobe, b_irq, m_irq;
   logic [7:0] raw_w, cnt_w, stat_w, raw_r, cnt_r, q, raw_seen, awaddr, araddr;
   logic [3:0] pls, lvl;
   logic [15:0] ctl_r;
   logic [31:0] wdata, rdata, r;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;
   int strobes = 0;
   int n;
   csrb_if csrb_if_i();
   csrb_bank #(.SLAVE_ID(SID), .NP(4), .NL(4)) csrb_bank_i (.clk_sys(clk_sys), .srst(srst),
      .bus(csrb_if_i), .raw_w(raw_w), .raw_r(raw_r), .bus_write_strobe(bus_write_strobe),
      .ctl_r(ctl_r), .cnt_r(cnt_r), .cnt_w(cnt_w), .cnt_we(cnt_we), .stat_w(stat_w),
      .pulse_event_input(pls), .falling_edge_event_input(lvl), .irq(b_irq));
   csrb_master csrb_master_i (.clk_sys(clk_sys), .srst(srst), .bus(csrb_if_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq(m_irq));
   csrb_bank_monitor #(.SLAVE_ID(SID)) csrb_bank_monitor_i (.clk_sys(clk_sys), .srst(srst),
      .adr(csrb_if_i.adr), .we(csrb_if_i.we), .dat_w(csrb_if_i.dat_w), .dat_r(csrb_if_i.dat_r),
      .raw_w(raw_w), .raw_r(raw_r), .bus_write_strobe(bus_write_strobe), .ctl_r(ctl_r),
      .stat_w(stat_w), .irq(b_irq));
   // ----------------------------------------
   // Clock, timeout and strobe watch
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         end_of_test();
      end
      if (bus_write_strobe === 1'b1) begin
         strobes = strobes + 1;
         raw_seen = raw_r;
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("errors %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(posedge clk_sys); while (!(awready === 1'b1 && wready === 1'b1));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b1;
      do @(posedge clk_sys); while (bvalid !== 1'b1);
      chk(bresp, csrb_pkg::RESP_OKAY);
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk_sys); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge clk_sys); while (rvalid !== 1'b1);
      d = rdata;
      chk(rresp, csrb_pkg::RESP_OKAY);
      rready <= 1'b0;
   endtask
   // One control bus transfer, steered through the master's registers.
   task automatic csr_op(input logic wr, input logic [4:0] sl, input logic [8:0] idx,
                         input logic [7:0] d);
      axi_wr(csrb_pkg::OFS_ADDR, {18'h0, sl, idx});
      axi_wr(csrb_pkg::OFS_WDATA, {24'h0, d});
      axi_wr(csrb_pkg::OFS_CMD, {30'h0, wr, 1'b1});
      do axi_rd(csrb_pkg::OFS_CMD, r); while (r[0] !== 1'b0);
      axi_rd(csrb_pkg::OFS_RDATA, r);
      q = r[7:0];
   endtask
   task automatic bw(input logic [8:0] idx, input logic [7:0] d);
      csr_op(1'b1, SID, idx, d);
   endtask
   task automatic br(input logic [8:0] idx);
      csr_op(1'b0, SID, idx, 8'h00);
   endtask
   task automatic do_reset();
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk(ctl_r, 16'h0000);
      chk(b_irq, 1'b0);
      br(csrb_pkg::IDX_EV_PEND);
      chk(q, 8'h00);
      br(csrb_pkg::IDX_EV_EN);
      chk(q, 8'h00);
   endtask
   task automatic t_raw();
      @(posedge clk_sys);
      raw_w <= 8'h3c;
      n = strobes;
      bw(csrb_pkg::IDX_RAW, 8'ha5);
      chk(strobes - n, 1);
      chk(raw_seen, 8'ha5);
      br(csrb_pkg::IDX_RAW);
      chk(q, 8'h3c);
   endtask
   task automatic t_ctl();
      bw(csrb_pkg::IDX_CTL_HI, 8'h12);
      bw(csrb_pkg::IDX_CTL_LO, 8'h34);
      chk(ctl_r, 16'h1234);
      br(csrb_pkg::IDX_CTL_HI);
      chk(q, 8'h12);
      br(csrb_pkg::IDX_CTL_LO);
      chk(q, 8'h34);
      // A write aimed at another slave must leave this bank untouched.
      csr_op(1'b1, 5'h00, csrb_pkg::IDX_CTL_HI, 8'hff);
      chk(ctl_r, 16'h1234);
      csr_op(1'b0, 5'h00, csrb_pkg::IDX_CTL_LO, 8'h00);
      chk(q, 8'h00);
   endtask
   task automatic t_cnt_stat();
      @(posedge clk_sys);
      cnt_w <= 8'h77;
      cnt_we <= 1'b1;
      stat_w <= 8'h5a;
      @(posedge clk_sys);
      cnt_we <= 1'b0;
      @(posedge clk_sys);
      chk(cnt_r, 8'h77);
      br(csrb_pkg::IDX_CNT);
      chk(q, 8'h77);
      bw(csrb_pkg::IDX_CNT, 8'h21);
      chk(cnt_r, 8'h21);
      bw(csrb_pkg::IDX_STAT, 8'hff);
      br(csrb_pkg::IDX_STAT);
      chk(q, 8'h5a);
      stat_w <= 8'hc3;
      br(csrb_pkg::IDX_STAT);
      chk(q, 8'hc3);
   endtask
   task automatic t_events();
      @(posedge clk_sys);
      pls <= 4'h2;
      lvl <= 4'h5;
      @(posedge clk_sys);
      pls <= 4'h0;
      br(csrb_pkg::IDX_EV_PEND);
      chk(q, 8'h02);
      chk(b_irq, 1'b0);
      br(csrb_pkg::IDX_EV_STATUS);
      chk(q, 8'h50);
      lvl <= 4'h4;
      br(csrb_pkg::IDX_EV_PEND);
      chk(q, 8'h12);
      bw(csrb_pkg::IDX_EV_EN, 8'h10);
      chk(b_irq, 1'b1);
      br(csrb_pkg::IDX_EV_EN);
      chk(q, 8'h10);
      bw(csrb_pkg::IDX_EV_PEND, 8'h10);
      chk(b_irq, 1'b0);
      br(csrb_pkg::IDX_EV_PEND);
      chk(q, 8'h02);
      bw(csrb_pkg::IDX_EV_EN, 8'h02);
      chk(b_irq, 1'b1);
      do_reset();
      chk(b_irq, 1'b0);
      chk(ctl_r, 16'h0000);
      chk(cnt_r, 8'h00);
   endtask
   task automatic t_master_irq();
      csr_op(1'b0, SID, csrb_pkg::IDX_CNT, 8'h00);
      axi_rd(csrb_pkg::OFS_IRQ_STAT, r);
      chk(r[0], 1'b1);
      chk(m_irq, 1'b0);
      axi_wr(csrb_pkg::OFS_IRQ_MASK, 32'h1);
      axi_rd(csrb_pkg::OFS_IRQ_MASK, r);
      chk(m_irq, 1'b1);
      axi_wr(csrb_pkg::OFS_IRQ_STAT, 32'h1);
      axi_rd(csrb_pkg::OFS_IRQ_STAT, r);
      chk(r[0], 1'b0);
      chk(m_irq, 1'b0);
      axi_rd(8'h18, r);
      chk(r, 32'h0);
   endtask
   initial begin
      {srst, cnt_we, awvalid, wvalid, bready, arvalid, rready} = 7'h41;
      {raw_w, cnt_w, stat_w, awaddr, araddr} = 40'h0;
      {pls, lvl, wdata} = 40'h0;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      t_reset();
      t_raw();
      t_ctl();
      t_cnt_stat();
      t_events();
      t_master_irq();
      end_of_test();
   end
endmodule // csr_bank_with_event_manager_tb_top

/* File: test/csrb_bank_monitor.sv */
// Checker of the control bus between the master and the register bank.
module csrb_bank_monitor #(
   parameter logic [4:0] SLAVE_ID = 5'h00
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [13:0] adr,
   input wire logic we,
   input wire logic [7:0] dat_w,
   input wire logic [7:0] dat_r,
   input wire logic [7:0] raw_w,
   input wire logic [7:0] raw_r,
   input wire logic bus_write_strobe,
   input wire logic [15:0] ctl_r,
   input wire logic [7:0] stat_w,
   input wire logic irq
);
   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic sel;
   logic raw_wr;
   logic hi_wr;
   logic lo_wr;
   assign sel = adr[13:9] == SLAVE_ID;
   assign raw_wr = sel && we && adr[8:0] == csrb_pkg::IDX_RAW;
   assign hi_wr = sel && we && adr[8:0] == csrb_pkg::IDX_CTL_HI;
   assign lo_wr = sel && we && adr[8:0] == csrb_pkg::IDX_CTL_LO;
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   sequence s_raw_wr;
      raw_wr;
   endsequence
   sequence s_one_pulse;
      bus_write_strobe ##1 !bus_write_strobe;
   endsequence
   property p_strobe;
      s_raw_wr |=> s_one_pulse;
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("Strobe is not one pulse after a raw write.");
   property p_no_strobe;
      !raw_wr |=> !bus_write_strobe;
   endproperty
   a_no_strobe: assert property (p_no_strobe)
      else $error("Strobe without a raw write.");
   property p_raw_val;
      s_raw_wr |=> raw_r == $past(dat_w);
   endproperty
   a_raw_val: assert property (p_raw_val)
      else $error("Raw value differs from written byte.");
   property p_ctl_hi;
      hi_wr |=> ctl_r[15:8] == $past(dat_w);
   endproperty
   a_ctl_hi: assert property (p_ctl_hi)
      else $error("Upper control slice not loaded.");
   property p_ctl_lo;
      lo_wr |=> ctl_r[7:0] == $past(dat_w);
   endproperty
   a_ctl_lo: assert property (p_ctl_lo)
      else $error("Lower control slice not loaded.");
   property p_ctl_hold;
      !(hi_wr || lo_wr) |=> $stable(ctl_r);
   endproperty
   a_ctl_hold: assert property (p_ctl_hold)
      else $error("Control field changed without a write.");
   property p_raw_rd;
      sel && adr[8:0] == csrb_pkg::IDX_RAW |=> dat_r == $past(raw_w);
   endproperty
   a_raw_rd: assert property (p_raw_rd)
      else $error("Raw read does not return the core value.");
   property p_stat_rd;
      sel && adr[8:0] == csrb_pkg::IDX_STAT |=> dat_r == $past(stat_w);
   endproperty
   a_stat_rd: assert property (p_stat_rd)
      else $error("Status field read does not return core data.");
   property p_unsel;
      !sel |=> dat_r == 8'h00;
   endproperty
   a_unsel: assert property (p_unsel)
      else $error("Read data driven for another slave.");
   property p_reset;
      $fell(srst) |-> dat_r == 8'h00 && ctl_r == 16'h0000 && !irq && !bus_write_strobe;
   endproperty
   a_reset: assert property (p_reset)
      else $error("Outputs not cleared by reset.");
endmodule // csrb_bank_monitor
